// ---- src/ccm_clock_mode.sv ----
// ccm_clock_mode: clock mode control of a mono codec (mode decode, pll lock, clock pins)
// assumes: one 200 MHz clock, plain register port, link pins come from outside this domain
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "ccm_params.svh"
module ccm_clock_mode #(
    parameter int LOCK_FCK_CYC = `CCM_LOCK_FCK_MS * (`CCM_CLK_HZ / 1000),
    parameter int LOCK_BCK_CYC = `CCM_LOCK_BCK_MS * (`CCM_CLK_HZ / 1000),
    parameter int LOCK_MCK_CYC = `CCM_LOCK_MCK_MS * (`CCM_CLK_HZ / 1000),
    parameter int REF_TIMEOUT  = `CCM_REF_TIMEOUT
) (
    input  wire logic                      SYS_CLK,
    input  wire logic                      NRST,
    input  wire ccm_pkg::ccm_req_type      REQ,
    output logic [`CCM_DATA_W-1:0]         RDATA,
    input  wire logic                      MCLK_IN,
    input  wire logic                      BIT_CLOCK_I,
    input  wire logic                      FRAME_CLOCK_I,
    output ccm_pkg::ccm_pins_type          PINS,
    output logic                           MCLK_IN_PULLDOWN
);
    import ccm_pkg::*;

    localparam int CNT_W  = 26;
    localparam int IDLE_W = 17;

    if (LOCK_FCK_CYC < 1 || LOCK_FCK_CYC >= 2**CNT_W ||
        LOCK_BCK_CYC < 1 || LOCK_BCK_CYC >= 2**CNT_W ||
        LOCK_MCK_CYC < 1 || LOCK_MCK_CYC >= 2**CNT_W ||
        REF_TIMEOUT < 2 || REF_TIMEOUT >= 2**IDLE_W - 1) begin : g_chk
        $error("ccm_clock_mode: count parameter out of range");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic                   pll_power_on;
        logic                   master;
        logic                   mclk_out_en;
        logic                   mclk_in_pulldown;
        logic [1:0]             bitclk_out_rate;
        logic [3:0]             pll_ref_select;
        logic [3:0]             rate_select;
        logic [2:0]             sync1;
        logic [2:0]             sync2;
        logic                   ref_prev;
        logic [IDLE_W-1:0]      idle_cnt;
        logic [CNT_W-1:0]       lock_cnt;
        logic                   locked;
        logic [`CCM_ACC_W-1:0]  acc;
        logic [7:0]             div_cnt;
        logic [`CCM_DATA_W-1:0] rdata;
        ccm_pins_type           pins;
    } ccm_state_type;

    ccm_state_type st_q;
    ccm_state_type st_d;

    ccm_mode_type          mode;
    ccm_ref_type           ref_cls;
    logic                  ref_ok;
    logic                  rate_ok;
    logic                  ref_active;
    logic                  ref_sel_lvl;
    logic                  gen_ok;
    logic                  bco_ok;
    logic                  sel_change;
    logic [CNT_W-1:0]      lock_lim;
    logic [`CCM_ACC_W-1:0] step;
    logic [`CCM_ACC_W:0]   acc_sum;
    logic                  bck_gen;
    logic [7:0]            status;

    // ----------------------------------------
    // decode functions
    // ----------------------------------------
    function automatic ccm_ref_type ccm_ref_class(input logic [3:0] code);
        case (code)
            4'h0:                      return CCM_REF_FCK;
            4'h1, 4'h2, 4'h3:          return CCM_REF_BCK;
            4'h4, 4'h5, 4'h6, 4'h7,
            4'hC, 4'hD:                return CCM_REF_MCK;
            default:                   return CCM_REF_BAD;
        endcase
    endfunction

    function automatic logic [`CCM_ACC_W-1:0] ccm_step(input logic [3:0] code);
        longint fs;
        fs = 0;
        case (code)
            4'h0:    fs = `CCM_FS_8000;
            4'h1:    fs = `CCM_FS_12000;
            4'h2:    fs = `CCM_FS_16000;
            4'h3:    fs = `CCM_FS_24000;
            4'h4:    fs = `CCM_FS_7350;
            4'h5:    fs = `CCM_FS_11025;
            4'h6:    fs = `CCM_FS_14700;
            4'h7:    fs = `CCM_FS_22050;
            4'hA:    fs = `CCM_FS_32000;
            4'hB:    fs = `CCM_FS_48000;
            4'hE:    fs = `CCM_FS_29400;
            4'hF:    fs = `CCM_FS_44100;
            default: fs = 0;
        endcase
        return `CCM_ACC_W'((fs << 32) / `CCM_CLK_HZ);
    endfunction

    function automatic logic ccm_range_ok(input logic [3:0] code);
        case ({code[3], code[1:0]})
            3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7: return 1'b1;
            default:                            return 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // decode
    // ----------------------------------------
    always_comb begin
        case ({st_q.pll_power_on, st_q.master})
            2'b11:   mode = CCM_PLL_MASTER;
            2'b10:   mode = CCM_PLL_SLAVE;
            2'b00:   mode = CCM_EXT_SLAVE;
            default: mode = CCM_INVALID;
        endcase
        ref_cls = ccm_ref_class(st_q.pll_ref_select);
        ref_ok  = (ref_cls != CCM_REF_BAD);
        step    = ccm_step(st_q.rate_select);
        if (st_q.pll_ref_select[2]) begin
            rate_ok = (step != '0);
        end else begin
            rate_ok = ccm_range_ok(st_q.rate_select);
        end
        case (ref_cls)
            CCM_REF_FCK: lock_lim = CNT_W'(LOCK_FCK_CYC);
            CCM_REF_BCK: lock_lim = CNT_W'(LOCK_BCK_CYC);
            default:     lock_lim = CNT_W'(LOCK_MCK_CYC);
        endcase
        case (ref_cls)
            CCM_REF_FCK: ref_sel_lvl = st_q.sync2[0];
            CCM_REF_BCK: ref_sel_lvl = st_q.sync2[1];
            default:     ref_sel_lvl = st_q.sync2[2];
        endcase
        ref_active = (st_q.idle_cnt < IDLE_W'(REF_TIMEOUT));
        bco_ok     = (st_q.bitclk_out_rate != 2'h3);
        gen_ok     = st_q.pll_power_on && st_q.locked && ref_ok && rate_ok
                     && st_q.pll_ref_select[2];
        case (st_q.bitclk_out_rate)
            `CCM_BCO_16FS: bck_gen = st_q.div_cnt[3];
            `CCM_BCO_32FS: bck_gen = st_q.div_cnt[2];
            `CCM_BCO_64FS: bck_gen = st_q.div_cnt[1];
            default:       bck_gen = 1'b0;
        endcase
        status = {ref_active, rate_ok, st_q.locked, ref_ok, mode};
    end

    assign sel_change = REQ.wr && (REQ.addr == `CCM_OFS_SEL)
                        && (REQ.wdata != {st_q.rate_select, st_q.pll_ref_select});
    assign acc_sum    = {1'b0, st_q.acc} + {1'b0, step};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        // register writes take effect at the next edge
        if (REQ.wr && REQ.addr == `CCM_OFS_CTRL) begin
            st_d.pll_power_on     = REQ.wdata[`CCM_B_PLL_ON];
            st_d.master           = REQ.wdata[`CCM_B_MASTER];
            st_d.mclk_out_en      = REQ.wdata[`CCM_B_MCLK_EN];
            st_d.mclk_in_pulldown = REQ.wdata[`CCM_B_PULLDOWN];
            st_d.bitclk_out_rate  = REQ.wdata[`CCM_B_BCO_HI:`CCM_B_BCO_LO];
        end
        if (REQ.wr && REQ.addr == `CCM_OFS_SEL) begin
            st_d.pll_ref_select = REQ.wdata[3:0];
            st_d.rate_select    = REQ.wdata[7:4];
        end
        st_d.rdata = '0;
        if (REQ.rd) begin
            case (REQ.addr)
                `CCM_OFS_CTRL:   st_d.rdata = {2'h0, st_q.bitclk_out_rate,
                                               st_q.mclk_in_pulldown, st_q.mclk_out_en,
                                               st_q.master, st_q.pll_power_on};
                `CCM_OFS_SEL:    st_d.rdata = {st_q.rate_select, st_q.pll_ref_select};
                `CCM_OFS_STATUS: st_d.rdata = status;
                default:         st_d.rdata = '0;
            endcase
        end
        // pin synchronisers
        st_d.sync1    = {MCLK_IN, BIT_CLOCK_I, FRAME_CLOCK_I};
        st_d.sync2    = st_q.sync1;
        st_d.ref_prev = ref_sel_lvl;
        // reference activity watchdog
        if (ref_sel_lvl != st_q.ref_prev) begin
            st_d.idle_cnt = '0;
        end else if (ref_active) begin
            st_d.idle_cnt = st_q.idle_cnt + IDLE_W'(1);
        end
        // lock timer
        if (!st_q.pll_power_on || !ref_ok || !ref_active || sel_change) begin
            st_d.lock_cnt = '0;
            st_d.locked   = 1'b0;
        end else if (!st_q.locked) begin
            if (st_q.lock_cnt == lock_lim - CNT_W'(1)) begin
                st_d.locked = 1'b1;
            end else begin
                st_d.lock_cnt = st_q.lock_cnt + CNT_W'(1);
            end
        end
        // 256fs phase accumulator and fs divider
        if (gen_ok) begin
            st_d.acc = acc_sum[`CCM_ACC_W-1:0];
            if (!st_q.acc[`CCM_ACC_W-1] && acc_sum[`CCM_ACC_W-1]) begin
                st_d.div_cnt = st_q.div_cnt + 8'h01;
            end
        end else begin
            st_d.acc     = '0;
            st_d.div_cnt = '0;
        end
        // pins
        st_d.pins.mclk_out = gen_ok && st_q.mclk_out_en
                             && st_q.acc[`CCM_ACC_W-1];
        st_d.pins.bit_clock_oe   = st_q.master;
        st_d.pins.frame_clock_oe = st_q.master;
        if (mode == CCM_PLL_MASTER && gen_ok && bco_ok) begin
            st_d.pins.bit_clock_o   = bck_gen;
            st_d.pins.frame_clock_o = st_q.div_cnt[7];
        end else begin
            st_d.pins.bit_clock_o   = 1'b0;
            st_d.pins.frame_clock_o = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            st_q                  <= '0;
            st_q.mclk_in_pulldown <= 1'(`CCM_CTRL_RST >> `CCM_B_PULLDOWN);
            st_q.master           <= 1'b0;
            st_q.pll_ref_select   <= 4'(`CCM_SEL_RST);
            st_q.rate_select      <= 4'(`CCM_SEL_RST >> 4);
            // reference counts as absent until its first edge
            st_q.idle_cnt         <= IDLE_W'(REF_TIMEOUT);
        end else begin
            st_q <= st_d;
        end
    end

    assign RDATA            = st_q.rdata;
    assign PINS             = st_q.pins;
    assign MCLK_IN_PULLDOWN = st_q.mclk_in_pulldown;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    sequence seq_ctrl_wr;
        REQ.wr && REQ.addr == `CCM_OFS_CTRL;
    endsequence
    sequence seq_lock_restart;
        sel_change ##1 (!st_q.locked && st_q.lock_cnt == '0);
    endsequence
    sequence seq_rate_wr;
        REQ.wr && REQ.addr == `CCM_OFS_SEL && REQ.wdata[7:4] != st_q.rate_select;
    endsequence
    sequence seq_lock_clear;
        !st_q.locked && st_q.lock_cnt == '0;
    endsequence

    AST_MODE_DECODE: assert property (
        (mode == CCM_PLL_MASTER) == (st_q.pll_power_on && st_q.master)
        && (mode == CCM_EXT_SLAVE) == (!st_q.pll_power_on && !st_q.master))
        else $error("mode decode wrong");
    AST_INVALID_DRIVE: assert property (
        mode == CCM_INVALID |=> PINS.bit_clock_oe && !PINS.bit_clock_o && !PINS.mclk_out)
        else $error("invalid mode pins wrong");
    AST_PULLDOWN: assert property (
        seq_ctrl_wr |=> MCLK_IN_PULLDOWN == $past(REQ.wdata[`CCM_B_PULLDOWN]))
        else $error("pulldown bit not applied");
    AST_MCLK_OUT_LOW: assert property (
        !st_q.mclk_out_en |=> !PINS.mclk_out)
        else $error("mclk out not low while disabled");
    AST_EXT_MCLK_OUT: assert property (
        mode == CCM_EXT_SLAVE |=> !PINS.mclk_out [*2])
        else $error("mclk out active in ext slave");
    AST_MS_WRITE: assert property (
        seq_ctrl_wr |=> st_q.master == $past(REQ.wdata[`CCM_B_MASTER]))
        else $error("master bit not stored");
    AST_RESET_SLAVE: assert property (
        $rose(NRST) |-> !st_q.master && !PINS.bit_clock_oe)
        else $error("not slave after reset");
    AST_FLOAT: assert property (
        !st_q.master |=> !PINS.bit_clock_oe && !PINS.frame_clock_oe)
        else $error("clock pins driven in slave");
    AST_BAD_CODE: assert property (
        !ref_ok |=> !PINS.mclk_out && !PINS.bit_clock_o && !PINS.frame_clock_o)
        else $error("clocks active on illegal code");
    AST_LOCK_RESTART: assert property (
        st_q.pll_power_on && ref_ok && ref_active |-> sel_change |-> seq_lock_restart)
        else $error("lock not restarted on change");
    AST_LOCK_TIME: assert property (
        $rose(st_q.locked) |-> $past(st_q.lock_cnt) == lock_lim - CNT_W'(1))
        else $error("lock time wrong");
    AST_REF_CODES: assert property (
        ref_ok == (st_q.pll_ref_select inside {[4'h0:4'h7], 4'hC, 4'hD}))
        else $error("reference code decode wrong");
    AST_RATE_FIXED: assert property (
        st_q.pll_ref_select[2]
        |-> rate_ok == (st_q.rate_select inside {[4'h0:4'h7], 4'hA, 4'hB, 4'hE, 4'hF}))
        else $error("fixed rate decode wrong");
    AST_RATE_RANGE: assert property (
        !st_q.pll_ref_select[2] |-> rate_ok == (!st_q.rate_select[3] || st_q.rate_select[1]))
        else $error("rate range decode wrong");
    AST_BCO_BAD: assert property (
        st_q.bitclk_out_rate == 2'h3 |=> !PINS.bit_clock_o && !PINS.frame_clock_o)
        else $error("clocks active on bad bit clock rate");
    AST_PLL_OFF: assert property (
        !st_q.pll_power_on |=> !PINS.mclk_out && !PINS.bit_clock_o && !PINS.frame_clock_o)
        else $error("clocks generated with pll off");
    AST_SLAVE_LOW: assert property (
        mode != CCM_PLL_MASTER |=> !PINS.bit_clock_o && !PINS.frame_clock_o)
        else $error("bit or frame clock driven outside master mode");
    AST_PLL_OFF_UNLOCK: assert property (
        !st_q.pll_power_on |=> !st_q.locked)
        else $error("lock kept with pll off");
    AST_MASTER_OE: assert property (
        st_q.master |=> PINS.bit_clock_oe && PINS.frame_clock_oe)
        else $error("clock pins not driven in master");
    AST_RATE_RESTART: assert property (
        seq_rate_wr |=> seq_lock_clear)
        else $error("lock not restarted on rate change");
endmodule

// ---- src/ccm_params.svh ----
// ccm_params.svh: offsets, fields, reset values and timing of the clock mode control
// assumes: included by ccm_pkg, ccm_clock_mode and tb_top
`ifndef CCM_PARAMS_SVH
`define CCM_PARAMS_SVH
// ----------------------------------------
// clock and bus
// ----------------------------------------
`define CCM_CLK_HZ        200000000
`define CCM_ADDR_W        2
`define CCM_DATA_W        8
`define CCM_OFS_CTRL      2'h0
`define CCM_OFS_SEL       2'h1
`define CCM_OFS_STATUS    2'h2
`define CCM_CTRL_RST      8'h08
`define CCM_SEL_RST       8'h00
// ----------------------------------------
// control fields
// ----------------------------------------
`define CCM_B_PLL_ON      0
`define CCM_B_MASTER      1
`define CCM_B_MCLK_EN     2
`define CCM_B_PULLDOWN    3
`define CCM_B_BCO_LO      4
`define CCM_B_BCO_HI      5
`define CCM_BCO_16FS      2'h0
`define CCM_BCO_32FS      2'h1
`define CCM_BCO_64FS      2'h2
// ----------------------------------------
// lock times in ms, reference watchdog
// ----------------------------------------
`define CCM_LOCK_FCK_MS   160
`define CCM_LOCK_BCK_MS   2
`define CCM_LOCK_MCK_MS   40
`define CCM_REF_TIMEOUT   65000
// ----------------------------------------
// sampling rates in Hz
// ----------------------------------------
`define CCM_FS_8000       8000
`define CCM_FS_12000      12000
`define CCM_FS_16000      16000
`define CCM_FS_24000      24000
`define CCM_FS_7350       7350
`define CCM_FS_11025      11025
`define CCM_FS_14700      14700
`define CCM_FS_22050      22050
`define CCM_FS_32000      32000
`define CCM_FS_48000      48000
`define CCM_FS_29400      29400
`define CCM_FS_44100      44100
`define CCM_ACC_W         24
`endif

// ---- src/ccm_pkg.sv ----
// ccm_pkg: mode, reference, request and pin types of the clock mode control
// assumes: ccm_params.svh on the include path
package ccm_pkg;
`include "ccm_params.svh"
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        CCM_PLL_MASTER = 4'h1,
        CCM_PLL_SLAVE  = 4'h2,
        CCM_EXT_SLAVE  = 4'h4,
        CCM_INVALID    = 4'h8
    } ccm_mode_type;

    typedef enum logic [1:0] {
        CCM_REF_FCK = 2'h0,
        CCM_REF_BCK = 2'h1,
        CCM_REF_MCK = 2'h2,
        CCM_REF_BAD = 2'h3
    } ccm_ref_type;

    typedef struct packed {
        logic [`CCM_ADDR_W-1:0] addr;
        logic [`CCM_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } ccm_req_type;

    typedef struct packed {
        logic mclk_out;
        logic bit_clock_o;
        logic bit_clock_oe;
        logic frame_clock_o;
        logic frame_clock_oe;
    } ccm_pins_type;
endpackage

// ---- sim/ccm_host_model.sv ----
// ccm_host_model.sv: far-side audio host that supplies master, bit and frame clocks
// assumes: bench sets the run flags; pins released by both sides are pulled down
`timescale 1ns/1ps
module ccm_host_model (
    input  wire logic mclk_run,
    input  wire logic bck_run,
    input  wire logic mclk_pd,
    input  wire logic bit_o,
    input  wire logic bit_oe,
    input  wire logic frame_o,
    input  wire logic frame_oe,
    output logic      mclk_in,
    output logic      bit_wire,
    output logic      frame_wire
);
    logic       mck;
    logic       bck;
    logic [5:0] bcnt;
    // ----------------------------------------
    // free clocks, phase unrelated to system clock
    // ----------------------------------------
    initial begin
        mck = 1'b0;
        #3.1;
        forever #62.5 mck = ~mck;
    end
    initial begin
        bck = 1'b0;
        bcnt = 6'h00;
        #11.7;
        forever begin
            #62.5 bck = ~bck;
            if (!bck) bcnt = bcnt + 6'h01;
        end
    end
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    // master clock only once input pulldown is off
    assign mclk_in = (mclk_run && !mclk_pd) ? mck : 1'b0;
    // released pins follow the host clocks while bck_run, else fall to pull-down level
    assign bit_wire   = bit_oe ? bit_o : (bck_run ? bck : 1'b0);
    assign frame_wire = frame_oe ? frame_o : (bck_run ? bcnt[5] : 1'b0);
endmodule

// ---- sim/tb_top.sv ----
// tb_top.sv: self-checking bench of the clock mode control
// assumes: ccm_pkg compiled first, host model beside the block
`timescale 1ns/1ps
`include "ccm_params.svh"
module tb_top;
    import ccm_pkg::*;
    localparam int LCK = 100;
    logic         SYS_CLK;
    logic         NRST;
    ccm_req_type  req;
    logic [7:0]   RDATA;
    ccm_pins_type PINS;
    logic         pd;
    logic         mclk_w;
    logic         bit_w;
    logic         frm_w;
    logic         mclk_run;
    logic         bck_run;
    logic         rd_p = 1'b0;
    logic [7:0]   exp_q[$];
    logic [7:0]   msk_q[$];
    int           bad_count;
    int           total_checks;
    int           cyc;
    int           seed;
    int           nb;
    int           nm;
    int           nf;
    ccm_clock_mode #(.LOCK_FCK_CYC(150), .LOCK_BCK_CYC(60), .LOCK_MCK_CYC(LCK),
                     .REF_TIMEOUT(64)) u_dut (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .REQ(req), .RDATA(RDATA), .MCLK_IN(mclk_w),
        .BIT_CLOCK_I(bit_w), .FRAME_CLOCK_I(frm_w), .PINS(PINS), .MCLK_IN_PULLDOWN(pd));
    ccm_host_model u_host (
        .mclk_run(mclk_run), .bck_run(bck_run), .mclk_pd(pd),
        .bit_o(PINS.bit_clock_o), .bit_oe(PINS.bit_clock_oe),
        .frame_o(PINS.frame_clock_o), .frame_oe(PINS.frame_clock_oe),
        .mclk_in(mclk_w), .bit_wire(bit_w), .frame_wire(frm_w));
    // ----------------------------------------
    // clock, timeout, verdict
    // ----------------------------------------
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    task automatic test_done();
        if (bad_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] e);
        total_checks++;
        if (seen !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, seen);
        end
    endtask
    // ----------------------------------------
    // register bus and read monitor
    // ----------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge SYS_CLK);
        req.wr <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge SYS_CLK);
        req.rd <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    always @(posedge SYS_CLK) begin
        if (rd_p) check("rdata", {8'h00, RDATA & msk_q[0]}, {8'h00, exp_q[0]});
        if (rd_p) void'(exp_q.pop_front());
        if (rd_p) void'(msk_q.pop_front());
        rd_p <= req.rd && NRST;
    end
    // edges counted from one frame rise to the next; mclk edges over the whole window when win is below 1000
    task automatic meas(input int win, output int b, output int m, output int f);
        logic pb;
        logic pm;
        logic pf;
        b = 0;
        m = 0;
        f = 0;
        pb = PINS.bit_clock_o;
        pm = PINS.mclk_out;
        pf = PINS.frame_clock_o;
        for (int i = 0; i < win && f < 2; i++) begin
            @(negedge SYS_CLK);
            if (PINS.frame_clock_o === 1'b1 && pf === 1'b0) f++;
            if (f == 1 && PINS.bit_clock_o === 1'b1 && pb === 1'b0) b++;
            if ((f == 1 || win < 1000) && PINS.mclk_out === 1'b1 && pm === 1'b0) m++;
            pb = PINS.bit_clock_o;
            pm = PINS.mclk_out;
            pf = PINS.frame_clock_o;
        end
        @(posedge SYS_CLK);
    endtask
    task automatic pins(input logic oe, input logic p);
        @(negedge SYS_CLK);
        check("frame_oe", {15'h0, PINS.frame_clock_oe}, {15'h0, oe});
        check("bit_oe", {15'h0, PINS.bit_clock_oe}, {15'h0, oe});
        check("mclk_out", {15'h0, PINS.mclk_out}, 16'h0000);
        check("pulldown", {15'h0, pd}, {15'h0, p});
        @(posedge SYS_CLK);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        req = '0;
        NRST = 1'b0;
        mclk_run = 1'b0;
        bck_run = 1'b0;
        seed = 80007;
        repeat (12) @(posedge SYS_CLK);
        NRST <= 1'b1;
        @(posedge SYS_CLK);
        pins(1'b0, 1'b1);
        rd(`CCM_OFS_CTRL, `CCM_CTRL_RST, 8'hFF);
        rd(`CCM_OFS_SEL, `CCM_SEL_RST, 8'hFF);
        rd(`CCM_OFS_STATUS, 8'h54, 8'hFF);
        wr(2'h3, 8'($random(seed)));
        rd(2'h3, 8'h00, 8'hFF);
        rd(`CCM_OFS_CTRL, `CCM_CTRL_RST, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wr(`CCM_OFS_CTRL, {6'h01, i[1], i[0]});
            rd(`CCM_OFS_STATUS, (i == 0) ? 8'h04 : (i == 1) ? 8'h02 :
               (i == 2) ? 8'h08 : 8'h01, 8'h0F);
            pins(i[1], 1'b0);
        end
        wr(`CCM_OFS_CTRL, 8'h01);
        for (int r = 0; r < 16; r++) begin
            wr(`CCM_OFS_SEL, {4'h0, r[3:0]});
            rd(`CCM_OFS_STATUS, {3'h0, (r < 8 || r == 12 || r == 13), 4'h0},
               8'h10);
            wr(`CCM_OFS_SEL, {r[3:0], 4'h4});
            rd(`CCM_OFS_STATUS, {1'b0, (r < 8 || r == 10 || r == 11 || r > 13), 6'h0},
               8'h40);
            wr(`CCM_OFS_SEL, {r[3:0], 4'h1});
            rd(`CCM_OFS_STATUS, {1'b0, (!r[3] || r[1]), 6'h0}, 8'h40);
        end
        bck_run <= 1'b1;
        wr(`CCM_OFS_SEL, 8'h01);
        repeat (100) @(posedge SYS_CLK);
        rd(`CCM_OFS_STATUS, 8'hF2, 8'hFF);
        pins(1'b0, 1'b0);
        bck_run <= 1'b0;
        mclk_run <= 1'b1;
        wr(`CCM_OFS_SEL, 8'hB4);
        wr(`CCM_OFS_CTRL, 8'h07);
        repeat (LCK + 40) @(posedge SYS_CLK);
        rd(`CCM_OFS_STATUS, 8'hF1, 8'hFF);
        for (int b = 0; b < 3; b++) begin
            wr(`CCM_OFS_CTRL, {2'h0, b[1:0], 4'h7});
            meas(10000, nb, nm, nf);
            check("bit_per_frame", 16'(nb), 16'(16 << b));
            check("mclk_per_frame", 16'(nm), 16'd256);
        end
        wr(`CCM_OFS_CTRL, 8'h37);
        meas(5000, nb, nm, nf);
        check("frames_bco3", 16'(nf), 16'h0000);
        wr(`CCM_OFS_CTRL, 8'h03);
        meas(300, nb, nm, nf);
        check("mclk_disabled", 16'(nm), 16'h0000);
        wr(`CCM_OFS_CTRL, 8'h07);
        wr(`CCM_OFS_SEL, 8'hA4);
        rd(`CCM_OFS_STATUS, 8'h00, 8'h20);
        wr(`CCM_OFS_SEL, 8'h84);
        repeat (LCK + 40) @(posedge SYS_CLK);
        rd(`CCM_OFS_STATUS, 8'h01, 8'h4F);
        meas(300, nb, nm, nf);
        check("mclk_bad_rate", 16'(nm), 16'h0000);
        repeat (4) @(posedge SYS_CLK);
        // reset while master: block must come back as slave
        NRST <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        NRST <= 1'b1;
        @(posedge SYS_CLK);
        pins(1'b0, 1'b1);
        rd(`CCM_OFS_CTRL, `CCM_CTRL_RST, 8'hFF);
        repeat (4) @(posedge SYS_CLK);
        test_done();
    end
endmodule
